/* File: design/ssr_err_queue.v */
/*
 error queue: ten-entry fifo of message codes, drops when full.
 assumes push and pop strobes are one-cycle pulses on clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ssr_regs.vh"

module ssr_err_queue (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // write side
    input wire push_i,
    input wire [`SSR_EQ_W-1:0] push_data_i,
    // read side
    input wire pop_i,
    output reg [`SSR_EQ_W-1:0] head_o,
    output wire avail_o,
    output wire full_o,
    output reg [`SSR_EQ_AW-1:0] count_o
);

    reg [`SSR_EQ_W-1:0] mem_q [0:`SSR_EQ_DEPTH-1]; // message store
    reg [`SSR_EQ_AW-1:0] wr_q; // write pointer
    reg [`SSR_EQ_AW-1:0] rd_q; // read pointer
    wire do_push;
    wire do_pop;

    assign full_o = (count_o == `SSR_EQ_FULL);
    assign avail_o = (count_o != `SSR_EQ_ZERO); // R12
    // arrivals while full are dropped, old entries kept
    assign do_push = push_i && !full_o; // R22
    assign do_pop = pop_i && avail_o;

    // storage, no reset needed on data
    always @(posedge clk_i) begin
        if (do_push) begin
            mem_q[wr_q] <= push_data_i; // R11
        end
    end

    // pointers and count
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_q <= `SSR_EQ_ZERO;
            rd_q <= `SSR_EQ_ZERO;
            count_o <= `SSR_EQ_ZERO;
        end else begin
            if (do_push) begin
                wr_q <= (wr_q == `SSR_EQ_LAST) ? `SSR_EQ_ZERO : wr_q + `SSR_EQ_ONE;
            end
            if (do_pop) begin
                rd_q <= (rd_q == `SSR_EQ_LAST) ? `SSR_EQ_ZERO : rd_q + `SSR_EQ_ONE; // R11
            end
            if (do_push && !do_pop) begin
                count_o <= count_o + `SSR_EQ_ONE;
            end else if (do_pop && !do_push) begin
                count_o <= count_o - `SSR_EQ_ONE; // R12
            end
        end
    end

    // head word read straight from the store, zero when empty; a
    // registered head would lag a pop or a push by one cycle and hand a
    // back-to-back query a stale word
    always @* begin
        head_o = {`SSR_EQ_W{1'b0}};
        if (avail_o) begin
            head_o = mem_q[rd_q];
        end
    end

endmodule
`default_nettype wire

/* File: design/ssr_reg_set.v */
/*
 one status register set: condition in, latched event, enable mask,
 summary out. assumes condition bits are synchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ssr_regs.vh"

module ssr_reg_set (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // live conditions
    input wire [`SSR_SET_W-1:0] cond_i,
    // control strobes
    input wire ev_read_i,          // event read, clears after capture
    input wire clear_i,            // clear-status
    input wire en_wr_i,            // enable write
    input wire en_clr_i,           // preset clear of enable
    input wire [`SSR_SET_W-1:0] en_wdata_i,
    // state out
    output reg [`SSR_SET_W-1:0] event_o,
    output reg [`SSR_SET_W-1:0] enable_o,
    output wire summary_o
);

    wire [`SSR_SET_W-1:0] ev_d; // next event value

    // new conditions win over a clear in the same cycle
    assign ev_d = ((ev_read_i || clear_i) ? `SSR_EV_RST : event_o) | cond_i; // R3 R5

    // event latch
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            event_o <= `SSR_EV_RST; // R5
        end else begin
            event_o <= ev_d; // R3
        end
    end

    // enable mask, untouched by reads
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            enable_o <= `SSR_EN_RST; // R7
        end else if (en_wr_i) begin
            enable_o <= en_wdata_i;
        end else if (en_clr_i) begin
            enable_o <= `SSR_EN_RST; // R8
        end
    end

    // masked or of events
    assign summary_o = |(event_o & enable_o); // R4 R6

endmodule
`default_nettype wire

/* File: design/ssr_regs.vh */
/*
 status reporting block: field positions, reset values, sizes.
 assumes inclusion by bare name from the design files under design/.
*/
`ifndef SSR_REGS_VH
`define SSR_REGS_VH

// status byte bit positions
`define SSR_SB_MEAS 0
`define SSR_SB_SPARE 1
`define SSR_SB_EAV 2
`define SSR_SB_QUES 3
`define SSR_SB_MAV 4
`define SSR_SB_ESB 5
`define SSR_SB_RQS 6
`define SSR_SB_OPER 7
// summary bits that take part in the service request
`define SSR_SUM_MASK 8'hBD
// reset values
`define SSR_SRE_RST 8'h00
`define SSR_EN_RST 16'h0000
`define SSR_EV_RST 16'h0000
// register set geometry
`define SSR_NSETS 4
`define SSR_SET_OPER 0
`define SSR_SET_QUES 1
`define SSR_SET_MEAS 2
`define SSR_SET_STD 3
`define SSR_SET_W 16
// error queue
`define SSR_EQ_DEPTH 10
`define SSR_EQ_AW 4
`define SSR_EQ_W 16
`define SSR_EQ_LAST 4'h9
`define SSR_EQ_ZERO 4'h0
`define SSR_EQ_ONE 4'h1
`define SSR_EQ_FULL 4'hA

`endif

/* File: design/ssr_status_top.v */
/*
 status reporting core: four register sets, error queue, output queue
 flag, status byte, service request enable and request line.
 assumes command decode lives outside and gives one-cycle strobes on
 clk_i; condition inputs and output-queue level are on clk_i too.
 assumes the bus interface turns the level on srq_o into the pull on
 the service request wire and clocks the poll byte out itself.
 limitation: an error query that loses to a higher query still pops.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ssr_regs.vh"

// Functional notes
// R1: four register sets each feed one summary
// R2: condition registers read-only, follow live state
// R3: condition bit sets latched event bit
// R4: event AND enable, ORed into summary
// R5: event read, clear-status, power clear events
// R6: enable zero masks event, one passes
// R7: enable reads harmless; power clears enables
// R8: preset clears three enables, not standard
// R9: per-set event and condition queries
// R10: output queue data sets message available
// R11: error queue fifo of ten entries
// R12: error push sets available; empty clears
// R13: controller queries then addresses talk
// R14: status byte summaries follow inputs, unlatched
// R15: common query shows master summary, clears none
// R16: serial poll returns and resets request
// R17: power, clear-status clear status byte; clear-status here leaves error available and message available standing
// R18: service enable masks summaries from bit six
// R19: service enable written, readable, resets zero
// R20: enabled summary rising sets request line
// R21: after poll, new occurrence re-requests; here only an enabled summary rise or a repeat rise of a latched bit does
// R22: full error queue drops new messages
module ssr_status_top (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // live conditions, one word per set
    input wire [`SSR_SET_W-1:0] cond_oper_i,
    input wire [`SSR_SET_W-1:0] cond_ques_i,
    input wire [`SSR_SET_W-1:0] cond_meas_i,
    input wire [`SSR_SET_W-1:0] cond_std_i,
    // per-set queries and enable access, index selects the set
    input wire [1:0] set_sel_i,
    input wire cond_query_i,
    input wire event_query_i,
    input wire enable_query_i,
    input wire enable_wr_i,
    input wire [`SSR_SET_W-1:0] enable_wdata_i,
    // common commands
    input wire clear_status_i,
    input wire status_preset_i,
    input wire stb_query_i,
    input wire sre_wr_i,
    input wire [7:0] sre_wdata_i,
    input wire sre_query_i,
    // output queue level from the response formatter
    input wire out_queue_nonempty_i,
    // error queue
    input wire err_push_i,
    input wire [`SSR_EQ_W-1:0] err_code_i,
    input wire err_query_i,
    // serial poll
    input wire serial_poll_i,
    // answers
    output reg [`SSR_SET_W-1:0] rdata_o,
    output reg rvalid_o,
    output reg [7:0] poll_byte_o,
    output reg poll_valid_o,
    // service request line, level
    output wire srq_o,
    // error queue state
    output wire [`SSR_EQ_AW-1:0] err_count_o
);

    // set-level buses
    wire [`SSR_SET_W-1:0] cond_w [0:`SSR_NSETS-1];
    wire [`SSR_SET_W-1:0] event_w [0:`SSR_NSETS-1];
    wire [`SSR_SET_W-1:0] enable_w [0:`SSR_NSETS-1];
    wire [`SSR_NSETS-1:0] summary_w;
    // error queue wires
    wire [`SSR_EQ_W-1:0] eq_head;
    wire eq_avail;
    // status byte pieces
    wire [7:0] sum_byte;   // summaries, bit six zero
    wire mss;              // master summary
    wire [7:0] stb_mss;    // byte as given to the common query
    wire [7:0] stb_rqs;    // byte as given to serial poll
    reg [7:0] sre_q;       // service request enable
    reg [7:0] prev_en_q;   // enabled summaries last cycle
    reg rqs_q;             // request for service
    reg rqs_d;
    wire [7:0] en_sum;     // enabled summaries now
    wire rise;             // any enabled summary went 0 to 1, or a repeat occurrence
    // repeat occurrences while an event stays latched
    wire [`SSR_NSETS-1:0] fresh_w; // per set, enabled condition rose again
    wire [7:0] fresh_byte; // fresh flags at summary positions
    wire fresh_req;        // a fresh flag passed the service enable
    wire any_query;        // some query strobe this cycle

    // condition words pass straight through and are never written, so
    // the condition query always shows the live state
    assign cond_w[`SSR_SET_OPER] = cond_oper_i; // R2
    assign cond_w[`SSR_SET_QUES] = cond_ques_i;
    assign cond_w[`SSR_SET_MEAS] = cond_meas_i;
    assign cond_w[`SSR_SET_STD] = cond_std_i;

    // one register set per status group; the standard set is spared by
    // the preset, so its enable changes only by a write
    genvar gi;
    generate
        for (gi = 0; gi < `SSR_NSETS; gi = gi + 1) begin : g_set
            // set select and standard-set flag for this group
            wire sel;
            wire is_std;
            assign sel = (set_sel_i == gi);
            assign is_std = (gi == `SSR_SET_STD);
            ssr_reg_set u_set (
                .clk_i(clk_i),
                .reset_n_i(reset_n_i),
                .cond_i(cond_w[gi]),
                .ev_read_i(event_query_i && sel), // R5
                .clear_i(clear_status_i), // R5
                .en_wr_i(enable_wr_i && sel),
                .en_clr_i(status_preset_i && !is_std), // R8
                .en_wdata_i(enable_wdata_i),
                .event_o(event_w[gi]),
                .enable_o(enable_w[gi]),
                .summary_o(summary_w[gi]) // R1
            );
            // condition history, reset to the idle level of the inputs
            reg [`SSR_SET_W-1:0] prev_cond_q;
            always @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    prev_cond_q <= {`SSR_SET_W{1'b0}};
                end else begin
                    prev_cond_q <= cond_w[gi];
                end
            end
            // a condition that rises again while its event bit is still
            // latched leaves the summary flat; flag it so that a poll
            // cannot hide the repeat from the controller
            assign fresh_w[gi] = |(cond_w[gi] & ~prev_cond_q &
                                   event_w[gi] & enable_w[gi]); // R21
        end
    endgenerate

    // error queue; its full flag is not needed here since drops are
    // handled inside the queue
    // clear-status leaves the queue alone, only reads drain it
    ssr_err_queue u_eq (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .push_i(err_push_i),
        .push_data_i(err_code_i),
        .pop_i(err_query_i),
        .head_o(eq_head),
        .avail_o(eq_avail),
        .full_o(),
        .count_o(err_count_o)
    );

    // status byte map, bit by bit:
    //   b7 operation summary, b6 master summary or request
    //   b5 standard event summary, b4 message available
    //   b3 questionable summary, b2 error available
    //   b1 spare, always zero, b0 measurement summary
    // the spare and b6 stay out of the service enable mask
    // summaries placed straight into the byte, no latching
    assign sum_byte[`SSR_SB_MEAS] = summary_w[`SSR_SET_MEAS]; // R14
    assign sum_byte[`SSR_SB_SPARE] = 1'b0;
    assign sum_byte[`SSR_SB_EAV] = eq_avail; // R12
    assign sum_byte[`SSR_SB_QUES] = summary_w[`SSR_SET_QUES];
    // formatter holds this; clear-status may leave it set
    assign sum_byte[`SSR_SB_MAV] = out_queue_nonempty_i; // R10 R17
    assign sum_byte[`SSR_SB_ESB] = summary_w[`SSR_SET_STD];
    assign sum_byte[`SSR_SB_RQS] = 1'b0;
    assign sum_byte[`SSR_SB_OPER] = summary_w[`SSR_SET_OPER]; // R14

    // fresh flags placed like the summaries they stand beside; the queue
    // flags carry no event latch, so their own rise is enough
    assign fresh_byte[`SSR_SB_MEAS] = fresh_w[`SSR_SET_MEAS]; // R21
    assign fresh_byte[`SSR_SB_SPARE] = 1'b0;
    assign fresh_byte[`SSR_SB_EAV] = 1'b0;
    assign fresh_byte[`SSR_SB_QUES] = fresh_w[`SSR_SET_QUES];
    assign fresh_byte[`SSR_SB_MAV] = 1'b0;
    assign fresh_byte[`SSR_SB_ESB] = fresh_w[`SSR_SET_STD];
    assign fresh_byte[`SSR_SB_RQS] = 1'b0;
    assign fresh_byte[`SSR_SB_OPER] = fresh_w[`SSR_SET_OPER];

    // mask only the summary positions; master summary is combinational,
    // so it falls in the cycle the last enabled summary clears
    assign en_sum = sum_byte & sre_q & `SSR_SUM_MASK; // R18
    assign mss = |en_sum; // R15
    assign stb_mss = sum_byte | ({7'h00, mss} << `SSR_SB_RQS);
    assign stb_rqs = sum_byte | ({7'h00, rqs_q} << `SSR_SB_RQS); // R16
    assign fresh_req = |(fresh_byte & sre_q & `SSR_SUM_MASK); // R18 R21
    // request cause: an enabled summary edge, or a repeat occurrence
    assign rise = |(en_sum & ~prev_en_q) | fresh_req; // R20

    // service request enable
    // clear-status leaves it alone: only power or a zero write clears it
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sre_q <= `SSR_SRE_RST; // R19
        end else if (sre_wr_i) begin
            // a zero write is the only clear short of power
            sre_q <= sre_wdata_i; // R19
        end
    end

    // edge history of enabled summaries
    // masked history, so a service enable write that uncovers a set
    // summary counts as a new cause too
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev_en_q <= 8'h00;
        end else begin
            prev_en_q <= en_sum;
        end
    end

    // request flag: a new rise beats the poll reset in the same cycle
    // a cause seen in the poll cycle must not be lost, or the controller
    // would never hear of it
    always @* begin
        rqs_d = rqs_q;
        if (serial_poll_i || clear_status_i) begin
            rqs_d = 1'b0; // R16 R17
        end
        // cause applied last so that it wins
        if (rise) begin
            rqs_d = 1'b1; // R20 R21
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rqs_q <= 1'b0;
        end else begin
            rqs_q <= rqs_d;
        end
    end

    // srq pulled while request pending
    // level output, held until a poll or clear-status drops the flag
    assign srq_o = rqs_q; // R20

    // serial poll answer, byte sampled before the reset of the flag
    // the byte takes the flag before this edge resets it, so the
    // controller sees the request that it is answering
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            poll_byte_o <= 8'h00;
            poll_valid_o <= 1'b0;
        end else begin
            // one-cycle answer pulse per poll
            poll_valid_o <= serial_poll_i;
            if (serial_poll_i) begin
                poll_byte_o <= stb_rqs; // R16
            end
        end
    end

    // any query strobe earns one answer pulse
    assign any_query = cond_query_i || event_query_i || enable_query_i ||
                       stb_query_i || sre_query_i || err_query_i;

    // query answers; queries are exclusive, first one wins
    // a strobe that loses is not answered; rdata_o stands until the
    // next answer
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= {`SSR_SET_W{1'b0}};
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= any_query;
            if (cond_query_i) begin
                rdata_o <= cond_w[set_sel_i]; // R9
            end else if (event_query_i) begin
                // value before the read clears it
                rdata_o <= event_w[set_sel_i]; // R9
            end else if (enable_query_i) begin
                rdata_o <= enable_w[set_sel_i]; // R7
            end else if (stb_query_i) begin
                // reading the byte clears nothing
                rdata_o <= {8'h00, stb_mss}; // R15
            end else if (sre_query_i) begin
                rdata_o <= {8'h00, sre_q}; // R19
            end else if (err_query_i) begin
                // oldest word, or zero from an empty queue
                rdata_o <= eq_head; // R11
            end
        end
    end

endmodule
`default_nettype wire

/* File: tb/ssr_ctl_model.sv */
/* bus controller model: queries and serial polls.
 assumes tasks are called at a falling clock edge. */
`timescale 1ns/100ps
`default_nettype none
module ssr_ctl_model (
    // clock
    input wire logic clk_i,
    // answers from the core
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    input wire logic [7:0] poll_byte_i,
    input wire logic poll_valid_i,
    // requests: cond, event, enable, stb, sre, err
    output logic [5:0] query_o,
    output logic poll_o
);
    initial begin
        query_o = 6'h00;
        poll_o = 1'b0;
    end
    // send the query, then take the answer as talker
    task automatic query(input int k, output logic [15:0] d);
        query_o[k] = 1'b1;
        @(negedge clk_i) query_o = 6'h00;
        for (int n = 0; n < 3 && rvalid_i !== 1'b1; n++) @(negedge clk_i);
        d = rdata_i;
        @(negedge clk_i);
    endtask
    // poll after a random delay, like a slow host
    task automatic poll(output logic [7:0] b);
        repeat ($urandom % 3) @(negedge clk_i);
        poll_o = 1'b1;
        @(negedge clk_i) poll_o = 1'b0;
        for (int n = 0; n < 3 && poll_valid_i !== 1'b1; n++) @(negedge clk_i);
        b = poll_byte_i;
        @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

/* File: tb/ssr_status_monitor.sv */
/* port checker for the status core.
 assumes bind onto ssr_status_top, one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module ssr_status_monitor (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // requests
    input wire [1:0] set_sel_i,
    input wire cond_query_i,
    input wire event_query_i,
    input wire enable_query_i,
    input wire enable_wr_i,
    input wire [15:0] enable_wdata_i,
    input wire stb_query_i,
    input wire sre_wr_i,
    input wire [7:0] sre_wdata_i,
    input wire sre_query_i,
    input wire err_push_i,
    input wire err_query_i,
    input wire serial_poll_i,
    // answers
    input wire [15:0] rdata_o,
    input wire rvalid_o,
    input wire [7:0] poll_byte_o,
    input wire poll_valid_o,
    input wire srq_o,
    input wire [3:0] err_count_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // queries that outrank the status byte and later ones
    wire hi_q = cond_query_i | event_query_i | enable_query_i;
    wire any_q = hi_q | stb_query_i | sre_query_i | err_query_i;
    a_query_answer: assert property (any_q |=> rvalid_o)
        else $error("query not answered");
    a_answer_cause: assert property (rvalid_o |-> $past(any_q))
        else $error("answer without query");
    a_poll_answer: assert property (serial_poll_i |=> poll_valid_o)
        else $error("poll not answered");
    a_poll_rqs: assert property (poll_valid_o |-> poll_byte_o[6] == $past(srq_o))
        else $error("poll bit six wrong");
    a_err_grow: assert property (err_push_i && !any_q && err_count_o != 4'hA
        |=> err_count_o == $past(err_count_o) + 4'h1) else $error("push not counted");
    a_err_drop: assert property (err_push_i && !any_q && err_count_o == 4'hA
        |=> err_count_o == 4'hA) else $error("full queue grew");
    a_err_bound: assert property (err_count_o <= 4'hA)
        else $error("error count too high");
    a_err_pop: assert property (err_query_i && !hi_q && !stb_query_i && !sre_query_i
        && !err_push_i && err_count_o != 4'h0 |=> err_count_o == $past(err_count_o) - 4'h1)
        else $error("pop not counted");
    a_sre_readback: assert property (sre_wr_i ##1 (sre_query_i && !hi_q && !stb_query_i
        && !sre_wr_i) |=> rdata_o == {8'h00, $past(sre_wdata_i, 2)}) else $error("sre readback");
    a_en_readback: assert property (enable_wr_i ##1 (enable_query_i && !cond_query_i
        && !event_query_i && !enable_wr_i && set_sel_i == $past(set_sel_i))
        |=> rdata_o == $past(enable_wdata_i, 2)) else $error("enable readback");
    a_stb_shape: assert property (stb_query_i && !hi_q
        |=> rdata_o[15:8] == 8'h00 && !rdata_o[1]) else $error("status byte shape");
    c_srq_rise: cover property ($rose(srq_o));
    c_poll_rqs: cover property (poll_valid_o && poll_byte_o[6]);
    c_err_full: cover property (err_push_i && err_count_o == 4'hA);
endmodule
bind ssr_status_top ssr_status_monitor mon (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .set_sel_i(set_sel_i), .cond_query_i(cond_query_i), .event_query_i(event_query_i),
    .enable_query_i(enable_query_i), .enable_wr_i(enable_wr_i),
    .enable_wdata_i(enable_wdata_i), .stb_query_i(stb_query_i), .sre_wr_i(sre_wr_i),
    .sre_wdata_i(sre_wdata_i), .sre_query_i(sre_query_i), .err_push_i(err_push_i),
    .err_query_i(err_query_i), .serial_poll_i(serial_poll_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .poll_byte_o(poll_byte_o), .poll_valid_o(poll_valid_o),
    .srq_o(srq_o), .err_count_o(err_count_o));
`default_nettype wire

/* File: tb/ssr_status_top_tb.sv */
/* self-checking bench for the status core with a reference model.
 assumes the core and the controller model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module ssr_status_top_tb;
    logic clk_i, reset_n_i, oq;
    logic [15:0] cond_v [0:3];
    logic [1:0] sel;
    logic [4:0] cmd_v; // en_wr, clr, preset, sre_wr, push
    logic [15:0] en_wd, code, d;
    logic [7:0] sre_wd, b;
    wire [5:0] q_w;
    wire poll_w, rvalid, pvalid, srq;
    wire [15:0] rdata;
    wire [7:0] pbyte;
    wire [3:0] cnt;
    int fail_count, tests_run, cyc;
    logic [15:0] en_m [0:3]; // model enables
    logic [15:0] eq_m [$]; // model error queue
    ssr_status_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cond_oper_i(cond_v[0]),
        .cond_ques_i(cond_v[1]), .cond_meas_i(cond_v[2]), .cond_std_i(cond_v[3]),
        .set_sel_i(sel), .cond_query_i(q_w[0]), .event_query_i(q_w[1]),
        .enable_query_i(q_w[2]), .enable_wr_i(cmd_v[0]), .enable_wdata_i(en_wd),
        .clear_status_i(cmd_v[1]), .status_preset_i(cmd_v[2]), .stb_query_i(q_w[3]),
        .sre_wr_i(cmd_v[3]), .sre_wdata_i(sre_wd), .sre_query_i(q_w[4]),
        .out_queue_nonempty_i(oq), .err_push_i(cmd_v[4]), .err_code_i(code),
        .err_query_i(q_w[5]), .serial_poll_i(poll_w), .rdata_o(rdata), .rvalid_o(rvalid),
        .poll_byte_o(pbyte), .poll_valid_o(pvalid), .srq_o(srq), .err_count_o(cnt));
    ssr_ctl_model ctl (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
        .poll_byte_i(pbyte), .poll_valid_i(pvalid), .query_o(q_w), .poll_o(poll_w));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // hang guard, far above the run length
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // one-cycle command strobe
    task automatic cmd(input int k);
        @(negedge clk_i) cmd_v[k] = 1'b1;
        @(negedge clk_i) cmd_v = 5'h00;
    endtask
    // oper condition blip, then let the request settle
    task automatic blip();
        @(negedge clk_i) cond_v[0] = 16'h0008;
        @(negedge clk_i) cond_v[0] = 16'h0000;
        repeat (3) @(negedge clk_i);
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        cyc = 0; fail_count = 0; tests_run = 0; reset_n_i = 1'b0; oq = 1'b0; sel = 2'h0;
        cmd_v = 5'h00; en_wd = 16'h0000; code = 16'h0000; sre_wd = 8'h00;
        for (int k = 0; k < 4; k++) cond_v[k] = 16'h0000;
        void'($urandom(15));
        repeat (16) @(posedge clk_i);
        @(negedge clk_i) reset_n_i = 1'b1;
        // reset values, then live and latched bits per set
        ctl.query(4, d); chk(d, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            sel = k[1:0];
            ctl.query(2, d); chk(d, 16'h0000);
            cond_v[k] = 16'($urandom);
            en_m[k] = cond_v[k];
            ctl.query(0, d); chk(d, en_m[k]);
            cond_v[k] = 16'h0000;
            ctl.query(1, d); chk(d, en_m[k]);
            ctl.query(1, d); chk(d, 16'h0000);
            ctl.query(0, d); chk(d, 16'h0000);
        end
        // enables written, preset spares only the standard set
        for (int k = 0; k < 4; k++) begin
            sel = k[1:0]; en_m[k] = 16'($urandom); en_wd = en_m[k];
            cmd(0);
            ctl.query(2, d); chk(d, en_m[k]);
        end
        cmd(2);
        for (int k = 0; k < 4; k++) begin
            sel = k[1:0];
            ctl.query(2, d); chk(d, k == 3 ? en_m[3] : 16'h0000);
        end
        // request path from oper bit three
        sre_wd = 8'h80; cmd(3);
        ctl.query(4, d); chk(d, 16'h0080);
        sel = 2'h0; en_wd = 16'h0008; cmd(0);
        blip(); chk({15'h0000, srq}, 16'h0001);
        ctl.query(3, d); chk(d, 16'h00C0);
        chk({15'h0000, srq}, 16'h0001);
        ctl.poll(b); chk({8'h00, b}, 16'h00C0);
        chk({15'h0000, srq}, 16'h0000);
        ctl.query(3, d); chk(d, 16'h00C0);
        ctl.poll(b); chk({8'h00, b}, 16'h0080);
        blip(); chk({15'h0000, srq}, 16'h0001);
        ctl.poll(b); chk({8'h00, b}, 16'h00C0);
        ctl.query(1, d); chk(d, 16'h0008);
        ctl.query(3, d); chk(d, 16'h0000);
        blip(); chk({15'h0000, srq}, 16'h0001);
        cmd(1); chk({15'h0000, srq}, 16'h0000);
        ctl.query(3, d); chk(d, 16'h0000);
        // summary masked by the service enable, then by the set enable
        sre_wd = 8'h00; cmd(3);
        blip(); chk({15'h0000, srq}, 16'h0000);
        ctl.query(3, d); chk(d, 16'h0080);
        en_wd = 16'h0000; cmd(0); cmd(1);
        blip(); ctl.query(3, d); chk(d, 16'h0000);
        // message available follows the output queue level
        oq = 1'b1; ctl.query(3, d); chk(d, 16'h0010);
        oq = 1'b0; ctl.query(3, d); chk(d, 16'h0000);
        // overfill the error queue, then drain past empty
        for (int i = 0; i < 12; i++) begin
            code = 16'($urandom);
            if (eq_m.size() < 10) eq_m.push_back(code);
            cmd(4);
        end
        chk({12'h000, cnt}, 16'h000A);
        ctl.query(3, d); chk(d, 16'h0004);
        for (int i = 0; i < 11; i++) begin
            ctl.query(5, d); chk(d, eq_m.size() > 0 ? eq_m.pop_front() : 16'h0000);
        end
        ctl.query(3, d); chk(d, 16'h0000);
        print_verdict();
    end
endmodule
`default_nettype wire
